/* rtl/tec_pkg.sv */
/*
  Constants and carrier types for the timer/event counter with its
  count-clock selection. Assumes one 100 MHz core clock, a synchronous
  active-low reset, and that the CPU side issues one-cycle command strobes.
*/
// How it works
// - Four-bit mode register: source select, output enable.
// - Low bits pick system or count clock divider.
// - Top bit gates toggle flop onto pin.
// - Clock control muxes and prescales both clocks.
// - Counter adds one per count pulse.
// - Start command, match or reset clear counter.
// - Limit register loaded by its own command.
// - Reset sets limit register to all ones.
// - Comparator flags counter equal to limit.
// - Match raises top-priority timer interrupt, vector 10h.
// - Halt keeps the counter running normally.
// - Stop counts only from the count clock.
// - Registers kept; retention disables counter, count clock.
// - Stop left on timer, first external, serial, reset.
// - Halt left on reset or enabled interrupt.
// - Toggle output shares pin with port 2 bit 1.
package tec_pkg;

  localparam int MODE_W = 4;
  localparam int CNT_W = 8;
  localparam int PRE_W = 8;

  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] LIMIT_RST = 8'hFF;
  localparam logic [7:0] PRE_RST = 8'h00;

  // Prescaler terminal counts (divide ratio minus one)
  localparam logic [7:0] SYS_DIV256_LAST = 8'hFF;
  localparam logic [7:0] SYS_DIV32_LAST = 8'h1F;
  localparam logic [7:0] CNT_DIV64_LAST = 8'h3F;
  localparam logic [7:0] CNT_DIV8_LAST = 8'h07;

  localparam logic [7:0] TIMER_VECTOR = 8'h10;
  localparam int TIMER_PRIORITY = 1;

  typedef enum logic [2:0]
  {
    SEL_SYS_DIV256 = 3'h0,
    SEL_CNT_DIV64 = 3'h1,
    SEL_CNT_DIRECT_A = 3'h2,
    SEL_CNT_DIRECT_B = 3'h3,
    SEL_SYS_DIV32 = 3'h4,
    SEL_CNT_DIV8 = 3'h5,
    SEL_UNUSED_A = 3'h6,
    SEL_UNUSED_B = 3'h7
  } tec_sel_type;

  typedef struct packed
  {
    logic timer_output_enable;
    tec_sel_type count_select;
  } tec_mode_type;

  typedef enum logic [1:0]
  {
    PWR_RUN,
    PWR_HALT,
    PWR_STOP,
    PWR_RETAIN
  } tec_power_type;

  typedef struct packed
  {
    logic timer_match_interrupt;
    logic first_external_interrupt;
    logic second_external_interrupt;
    logic serial_done_interrupt;
  } tec_irq_type;

endpackage

/* rtl/tec_timer.sv */
/*
  Timer/event counter with clock mode register, prescalers, 8-bit
  counter, limit compare, toggle flop and power-down mode tracking.
  Assumes command strobes and interrupt flags come from core_clk logic;
  count_clock_input is an asynchronous pin and is synchronised here.
*/
module tec_timer
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic count_clock_input,
  input wire logic mode_write_command,
  input wire logic [3:0] mode_wdata,
  input wire logic limit_load_command,
  input wire logic [7:0] limit_wdata,
  input wire logic timer_start_command,
  input wire logic halt_command,
  input wire logic stop_command,
  input wire logic retention_request,
  input wire tec_pkg::tec_irq_type other_irq,
  input wire tec_pkg::tec_irq_type irq_enable,
  input wire logic port2_bit1,
  output logic [7:0] event_count_value,
  output logic timer_match_interrupt,
  output logic timer_toggle_pin,
  output logic timer_toggle_state,
  output logic [7:0] timer_vector,
  output tec_pkg::tec_power_type power_state,
  output logic cpu_clock_enable
);

  tec_pkg::tec_mode_type mode_q;
  logic [7:0] limit_q;
  logic [7:0] count_q;
  logic [7:0] sys_pre_q;
  logic [7:0] cnt_pre_q;
  logic [2:0] x_sync_q;
  logic toggle_q;
  logic irq_q;
  tec_pkg::tec_power_type pwr_q;
  logic x_edge;
  logic sys_run;
  logic cnt_run;
  logic count_pulse;
  logic match;
  logic wake_stop;
  logic wake_halt;

  function automatic logic pre_hit(input logic [7:0] v,
                                   input logic [7:0] last);
    pre_hit = (v & last) == last;
  endfunction

  // Count input synchronised; edge taken from second and third stages
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      x_sync_q <= 3'h0;
    else
      x_sync_q <= {x_sync_q[1:0], count_clock_input};
  end

  assign x_edge = x_sync_q[1] & ~x_sync_q[2];

  // System clock reaches the timer in run and halt, not stop or retention
  assign sys_run = (pwr_q == tec_pkg::PWR_RUN) ||
                   (pwr_q == tec_pkg::PWR_HALT);
  assign cnt_run = (pwr_q != tec_pkg::PWR_RETAIN);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      mode_q <= tec_pkg::MODE_RST;
    else if (mode_write_command && sys_run)
      mode_q <= tec_pkg::tec_mode_type'(mode_wdata);
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      limit_q <= tec_pkg::LIMIT_RST;
    else if (limit_load_command && sys_run)
      limit_q <= limit_wdata;
  end

  // Prescalers free-run while their clock is present
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      sys_pre_q <= tec_pkg::PRE_RST;
    else if (sys_run)
      sys_pre_q <= sys_pre_q + 8'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      cnt_pre_q <= tec_pkg::PRE_RST;
    else if (cnt_run && x_edge)
      cnt_pre_q <= cnt_pre_q + 8'h01;
  end

  // Source multiplexer
  always_comb
  begin
    count_pulse = 1'b0;
    unique case (mode_q.count_select)
      tec_pkg::SEL_SYS_DIV256:
        count_pulse = sys_run &&
                      pre_hit(sys_pre_q, tec_pkg::SYS_DIV256_LAST);
      tec_pkg::SEL_SYS_DIV32:
        count_pulse = sys_run &&
                      pre_hit(sys_pre_q, tec_pkg::SYS_DIV32_LAST);
      tec_pkg::SEL_CNT_DIV64:
        count_pulse = cnt_run && x_edge &&
                      pre_hit(cnt_pre_q, tec_pkg::CNT_DIV64_LAST);
      tec_pkg::SEL_CNT_DIV8:
        count_pulse = cnt_run && x_edge &&
                      pre_hit(cnt_pre_q, tec_pkg::CNT_DIV8_LAST);
      tec_pkg::SEL_CNT_DIRECT_A,
      tec_pkg::SEL_CNT_DIRECT_B:
        count_pulse = cnt_run && x_edge;
      tec_pkg::SEL_UNUSED_A,
      tec_pkg::SEL_UNUSED_B:
        count_pulse = 1'b0;
    endcase
  end

  assign match = (count_q == limit_q);

  // Match clears on the pulse that would step past the limit
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      count_q <= tec_pkg::COUNT_RST;
    else if (timer_start_command && sys_run)
      count_q <= tec_pkg::COUNT_RST;
    else if (count_pulse && match)
      count_q <= tec_pkg::COUNT_RST;
    else if (count_pulse)
      count_q <= count_q + 8'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      irq_q <= 1'b0;
    else
      irq_q <= count_pulse && match;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      toggle_q <= 1'b0;
    else if (count_pulse && match)
      toggle_q <= ~toggle_q;
  end

  // Wake conditions; second external interrupt ignored in stop
  assign wake_stop = irq_q || other_irq.first_external_interrupt ||
                     other_irq.serial_done_interrupt;
  assign wake_halt = (irq_q && irq_enable.timer_match_interrupt) ||
                     |(other_irq & irq_enable);

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      pwr_q <= retention_request ? tec_pkg::PWR_RETAIN
                                 : tec_pkg::PWR_RUN;
    else
      unique case (pwr_q)
        tec_pkg::PWR_RUN:
          if (stop_command)
            pwr_q <= tec_pkg::PWR_STOP;
          else if (halt_command)
            pwr_q <= tec_pkg::PWR_HALT;
        tec_pkg::PWR_HALT:
          if (wake_halt)
            pwr_q <= tec_pkg::PWR_RUN;
        tec_pkg::PWR_STOP:
          if (wake_stop)
            pwr_q <= tec_pkg::PWR_RUN;
        tec_pkg::PWR_RETAIN:
          pwr_q <= tec_pkg::PWR_RETAIN;
      endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      timer_toggle_pin <= 1'b0;
    else if (mode_q.timer_output_enable)
      timer_toggle_pin <= toggle_q;
    else
      timer_toggle_pin <= port2_bit1;
  end

  assign event_count_value = count_q;
  assign timer_match_interrupt = irq_q;
  assign timer_toggle_state = toggle_q;
  assign timer_vector = tec_pkg::TIMER_VECTOR;
  assign power_state = pwr_q;
  assign cpu_clock_enable = (pwr_q == tec_pkg::PWR_RUN);

endmodule

/* tb/tec_event_src.sv */
/* Event pulse source on the count clock pin.
   Started by the bench; pin idles low. */
module tec_event_src
(
  input wire logic go,
  input wire logic [7:0] n,
  input wire logic [5:0] half,
  output logic count_clock_input = 1'h0,
  output logic busy = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge go)
  begin
    busy = 1'h1;
    repeat (n)
    begin
      #(half * 10 + 3) count_clock_input = 1'h1;
      #(half * 10) count_clock_input = 1'h0;
    end
    busy = 1'h0;
  end
endmodule

/* tb/tec_properties.sv */
/* Port checker for tec_timer.
   Bound to each tec_timer instance; one clock domain. */
module tec_properties
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic timer_start_command,
  input wire tec_pkg::tec_irq_type other_irq,
  input wire logic [7:0] event_count_value,
  input wire logic timer_match_interrupt,
  input wire logic timer_toggle_state,
  input wire tec_pkg::tec_power_type power_state,
  input wire logic cpu_clock_enable
);
  wire [7:0] cv = event_count_value;
  wire tg = timer_toggle_state;
  wire irq = timer_match_interrupt;
  wire tec_pkg::tec_power_type ps = power_state;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  AST_CLR: assert property ($changed(tg) |-> cv == 8'h00)
    else $error("clear");
  AST_IRQ: assert property ($changed(tg) |-> irq)
    else $error("irq");
  AST_ONE: assert property (irq |=> !irq)
    else $error("pulse");
  AST_INC: assert property ($changed(cv) |->
    cv == $past(cv) + 8'h01 || cv == 8'h00) else $error("step");
  AST_CPU: assert property (
    cpu_clock_enable == (ps == tec_pkg::PWR_RUN)) else $error("cpu");
  AST_RET: assert property (
    ps == tec_pkg::PWR_RETAIN |=> $stable(cv)) else $error("retain");
  AST_GO: assert property (
    timer_start_command && !ps[1] |=> cv == 8'h00) else $error("start");
  AST_WAKE: assert property (ps == tec_pkg::PWR_STOP &&
    other_irq.first_external_interrupt |-> ##[1:8] ps == tec_pkg::PWR_RUN)
    else $error("wake");
  cover property (irq);
  cover property (ps == tec_pkg::PWR_STOP);
  cover property (ps == tec_pkg::PWR_RETAIN);
endmodule
bind tec_timer tec_properties i_props (.*);

/* tb/tec_timer_tb.sv */
/* Self-checking bench for tec_timer.
   Count pin is driven by tec_event_src. */
module tec_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk;
  logic nrst = 1'h0, retention_request = 1'h0, port2_bit1 = 1'h1;
  logic mode_write_command = 1'h0, limit_load_command = 1'h0;
  logic timer_start_command = 1'h0, halt_command = 1'h0;
  logic stop_command = 1'h0, go = 1'h0, count_clock_input, busy;
  logic [7:0] wd = 8'h00, n = 8'h00, c0, event_count_value, timer_vector;
  logic [5:0] half = 6'h03;
  tec_pkg::tec_irq_type other_irq = 4'h0, irq_enable = 4'h0;
  logic timer_match_interrupt, timer_toggle_pin, timer_toggle_state;
  logic cpu_clock_enable;
  tec_pkg::tec_power_type power_state;
  int fail_count = 0, check_count = 0, irq_n = 0, s;
  logic [7:0] evk [8] = '{8'h00, 8'h40, 8'h01, 8'h01,
    8'h00, 8'h08, 8'h04, 8'h04};
  tec_timer i_dut (.*, .mode_wdata(wd[3:0]), .limit_wdata(wd));
  tec_event_src i_src (.*);
  initial
  begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    irq_n <= irq_n + int'(timer_match_interrupt === 1'h1);
  task automatic chk(input logic [7:0] v, input logic [7:0] e, string w);
    check_count++;
    if (v !== e)
    begin
      $display("ERROR %s expected %h seen %h", w, e, v);
      fail_count++;
    end
  endtask
  task automatic final_report(input int f);
    fail_count += f;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  // Commands: stop, halt, start, limit, mode from high bit down
  task automatic op(input logic [4:0] c, input logic [7:0] d);
    @(posedge core_clk);
    {stop_command, halt_command, timer_start_command,
      limit_load_command, mode_write_command} <= c;
    wd <= d;
    @(posedge core_clk);
    {stop_command, halt_command, timer_start_command,
      limit_load_command, mode_write_command} <= 5'h00;
    #1;
  endtask
  task automatic ev(input logic [7:0] k, input logic [5:0] h);
    @(posedge core_clk);
    n <= k;
    half <= h;
    go <= 1'h1;
    @(posedge core_clk);
    go <= 1'h0;
    for (int i = 0; i < 9000 && busy !== 1'h0; i++)
      @(posedge core_clk);
    if (busy !== 1'h0)
      final_report(1);
    tick(5);
  endtask
  task automatic wake();
    for (int i = 0; i < 20 && power_state !== tec_pkg::PWR_RUN; i++)
      tick(1);
    chk(8'(power_state), 8'h00, "pwr");
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'h1;
    tick(2);
    chk(event_count_value, 8'h00, "cnt");
    chk(8'(timer_toggle_state), 8'h00, "tog");
    chk(timer_vector, 8'h10, "vec");
    op(5'h01, 8'h02);
    ev(8'hFF, 6'h03);
    chk(event_count_value, 8'hFF, "cnt");
    chk(8'(timer_toggle_pin), 8'h01, "pin");
    ev(8'h01, 6'h03);
    chk(event_count_value, 8'h00, "cnt");
    chk(8'(timer_toggle_state), 8'h01, "tog");
    chk(8'(irq_n), 8'h01, "irq");
    op(5'h01, 8'h0A);
    port2_bit1 <= 1'h0;
    tick(2);
    chk(8'(timer_toggle_pin), 8'h01, "pin");
    $display("count and limit test done");
    op(5'h02, 8'h03);
    ev(8'h02, 6'h14);
    chk(event_count_value, 8'h02, "cnt");
    op(5'h04, 8'h00);
    chk(event_count_value, 8'h00, "cnt");
    ev(8'h04, 6'h03);
    chk(event_count_value, 8'h00, "cnt");
    chk(8'(timer_toggle_pin), 8'h00, "pin");
    chk(8'(irq_n), 8'h02, "irq");
    $display("modulo test done");
    op(5'h02, 8'hFF);
    for (s = 0; s < 8; s++)
    begin
      op(5'h01, 8'(s));
      op(5'h04, 8'h00);
      c0 = event_count_value;
      if (evk[s] != 8'h00)
        ev(evk[s], 6'h03);
      tick(s == 0 ? 256 : s == 4 ? 32 : 0);
      chk(event_count_value, c0 + 8'(s < 6), "sel");
    end
    $display("select test done");
    op(5'h01, 8'h02);
    op(5'h08, 8'h00);
    chk(8'(cpu_clock_enable), 8'h00, "cpu");
    c0 = event_count_value;
    ev(8'h02, 6'h03);
    chk(event_count_value, c0 + 8'h02, "cnt");
    irq_enable <= 4'hF;
    other_irq <= 4'h4;
    wake();
    op(5'h11, 8'h04);
    other_irq <= 4'h2;
    c0 = event_count_value;
    tick(64);
    chk(8'(power_state), 8'h02, "pwr");
    chk(event_count_value, c0, "cnt");
    other_irq <= 4'h4;
    wake();
    $display("power test done");
    nrst <= 1'h0;
    retention_request <= 1'h1;
    tick(3);
    nrst <= 1'h1;
    tick(300);
    chk(8'(power_state), 8'h03, "pwr");
    chk(event_count_value, 8'h00, "cnt");
    nrst <= 1'h0;
    retention_request <= 1'h0;
    tick(3);
    nrst <= 1'h1;
    wake();
    $display("retention test done");
    final_report(0);
  end
endmodule
